// *** blink_gen.sv ***
`timescale 1ns/100ps
module blink_gen (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Generator settings and wave
  blink_if.gen bus
);

  logic [7:0] pre_ff;
  logic [7:0] count_ff;
  logic wave_ff;

  // ---------------------------------------------------------------
  // Step pacing and comparison
  // ---------------------------------------------------------------
  wire pre_done = (pre_ff >= bus.period);
  wire step = bus.step_tick && pre_done;
  wire [7:0] nxt_pre = pre_done ? 8'h00 : pre_ff + 8'h01;
  wire nxt_wave = (bus.duty != blink_pkg::DUTY_OFF) &&
                  (count_ff >= bus.duty);

  // The count steps once every period+1 base ticks, 256 steps a period.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pre_ff <= 8'h00;
      count_ff <= 8'h00;
      wave_ff <= 1'b0;
    end else begin
      if (bus.step_tick) begin
        pre_ff <= nxt_pre;
      end
      if (step) begin
        count_ff <= count_ff + 8'h01;
      end
      wave_ff <= nxt_wave;
    end
  end

  assign bus.wave = wave_ff;

endmodule

// *** blink_if.sv ***
`timescale 1ns/100ps
interface blink_if;
  logic step_tick;
  logic [7:0] period;
  logic [7:0] duty;
  logic wave;

  modport gen (
    input step_tick,
    input period,
    input duty,
    output wave
  );

  modport ctl (
    output step_tick,
    output period,
    output duty,
    input wave
  );
endinterface

// *** blink_pkg.sv ***
package blink_pkg;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ = 40_000_000;
  // Base blink rate in hertz for a prescaler value of zero.
  localparam int unsigned BASE_RATE_HZ = 44;
  localparam int unsigned STEPS_PER_PERIOD = 256;
  localparam int unsigned STEP_CYCLES =
    CLK_HZ / (BASE_RATE_HZ * STEPS_PER_PERIOD);
  localparam int unsigned STEP_CNT_W = 12;
  localparam logic [STEP_CNT_W-1:0] STEP_LAST =
    STEP_CNT_W'(STEP_CYCLES - 1);

  // ---------------------------------------------------------------
  // Register pointers
  // ---------------------------------------------------------------
  localparam logic [3:0] PTR_LEVEL_LOW = 4'h0;
  localparam logic [3:0] PTR_LEVEL_HIGH = 4'h1;
  localparam logic [3:0] PTR_BLINK_A_PERIOD = 4'h2;
  localparam logic [3:0] PTR_BLINK_A_DUTY = 4'h3;
  localparam logic [3:0] PTR_BLINK_B_PERIOD = 4'h4;
  localparam logic [3:0] PTR_BLINK_B_DUTY = 4'h5;
  localparam logic [3:0] PTR_ROUTE_0_3 = 4'h6;
  localparam logic [3:0] PTR_ROUTE_4_7 = 4'h7;
  localparam logic [3:0] PTR_ROUTE_8_11 = 4'h8;
  localparam logic [3:0] PTR_ROUTE_12_15 = 4'h9;
  localparam logic [3:0] PTR_LAST = 4'h9;
  localparam logic [3:0] PTR_ZERO = 4'h0;
  localparam logic [3:0] PTR_ONE = 4'h1;

  // ---------------------------------------------------------------
  // Control byte layout
  // ---------------------------------------------------------------
  localparam int unsigned CTRL_AUTO_STEP_BIT = 4;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] PERIOD_RESET = 8'hFF;
  localparam logic [7:0] DUTY_RESET = 8'h80;
  localparam logic [7:0] ROUTE_RESET = 8'h55;
  localparam logic [7:0] DUTY_OFF = 8'h00;

  // ---------------------------------------------------------------
  // Route selector codes
  // ---------------------------------------------------------------
  localparam logic [1:0] SEL_LOW = 2'h0;
  localparam logic [1:0] SEL_HIZ = 2'h1;
  localparam logic [1:0] SEL_WAVE_A = 2'h2;
  localparam logic [1:0] SEL_WAVE_B = 2'h3;

  // ---------------------------------------------------------------
  // Serial bus
  // ---------------------------------------------------------------
  localparam logic [3:0] DEV_PREFIX = 4'hC;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] BIT_ZERO = 4'h0;
  localparam logic [3:0] BIT_ONE = 4'h1;

  // ---------------------------------------------------------------
  // Input synchroniser
  // ---------------------------------------------------------------
  localparam int unsigned SYNC_W = 21;
  localparam logic [SYNC_W-1:0] SYNC_RESET = 21'h1FFFFF;

endpackage

// *** blinker_monitor.sv ***
`timescale 1ns/100ps
module blinker_monitor (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Serial bus
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  // Straps and driver pins
  input wire logic [2:0] addr_pin,
  input wire logic [15:0] driver_pin_in,
  input wire logic [15:0] driver_pin_out,
  input wire logic [15:0] driver_pin_oe
);
  // --------
  // Address byte
  // --------
  // Counts clock pulses after each start and keeps the first byte.
  logic scl_q_ff;
  logic sda_q_ff;
  logic [3:0] cnt_ff;
  logic [7:0] sh_ff;
  wire start_w = scl_in && scl_q_ff && sda_q_ff && !sda_in;
  wire rise_w = scl_in && !scl_q_ff;
  wire match_w = sh_ff[7:1] == {blink_pkg::DEV_PREFIX, addr_pin};
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      scl_q_ff <= 1'b1;
      sda_q_ff <= 1'b1;
      cnt_ff <= 4'hF;
      sh_ff <= 8'h00;
    end else begin
      scl_q_ff <= scl_in;
      sda_q_ff <= sda_in;
      if (start_w)
        cnt_ff <= 4'h0;
      else if (rise_w && cnt_ff != 4'hF)
        cnt_ff <= cnt_ff + 4'h1;
      if (rise_w && cnt_ff < 4'h8)
        sh_ff <= {sh_ff[6:0], sda_in};
    end
  end

  // --------
  // Checks
  // --------
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  rst_pins_a:
    assert property ($rose(reset_n) |-> driver_pin_oe == 16'h0000)
    else $error("Driver pins pulled after reset.");
  rst_bus_a:
    assert property ($rose(reset_n) |-> !sda_oe [*8])
    else $error("Data line pulled after reset.");
  open_drain_a:
    assert property (sda_out == 1'b0 && driver_pin_out == 16'h0000)
    else $error("Open-drain output driven high.");
  data_change_a:
    assert property ($rose(sda_oe) |-> !scl_in)
    else $error("Data pulled while clock high.");
  start_quiet_a:
    assert property (start_w |=> !sda_oe [*8])
    else $error("Data pulled right after start.");
  stop_quiet_a:
    assert property (scl_in && $rose(sda_in) |=> !sda_oe [*8])
    else $error("Data pulled on idle bus.");
  foreign_quiet_a:
    assert property (cnt_ff >= 4'h8 && !match_w |-> !sda_oe)
    else $error("Answer to a foreign address.");
  own_ack_a:
    assert property ($changed(cnt_ff) && cnt_ff == 4'h8 && match_w
      |-> ##[1:24] sda_oe)
    else $error("Own address not acknowledged.");
  cover property ($rose(sda_oe));
  cover property (cnt_ff == 4'h9 && !match_w);
  cover property ($fell(driver_pin_oe[2]));
endmodule

bind dual_rate_led_blinker blinker_monitor blinker_monitor_inst (
  .clk, .reset_n, .scl_in, .sda_in, .sda_out, .sda_oe, .addr_pin,
  .driver_pin_in, .driver_pin_out, .driver_pin_oe);

// *** dual_rate_led_blinker.sv ***
`timescale 1ns/100ps
module dual_rate_led_blinker (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Serial bus, open drain data line
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Address straps
  input wire logic [2:0] addr_pin,
  // Open-drain driver pins
  input wire logic [15:0] driver_pin_in,
  output logic [15:0] driver_pin_out,
  output logic [15:0] driver_pin_oe
);

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_CTRL,
    ST_WRITE,
    ST_READ
  } bus_state_t;

  // ---------------------------------------------------------------
  // Input synchroniser and filter
  // ---------------------------------------------------------------
  wire [blink_pkg::SYNC_W-1:0] raw_in = {addr_pin, driver_pin_in,
                                         sda_in, scl_in};
  logic [blink_pkg::SYNC_W-1:0] s1_ff;
  logic [blink_pkg::SYNC_W-1:0] s2_ff;
  logic [blink_pkg::SYNC_W-1:0] s3_ff;
  logic [blink_pkg::SYNC_W-1:0] filt_ff;
  logic [blink_pkg::SYNC_W-1:0] nxt_filt;

  genvar gi;
  generate
    for (gi = 0; gi < blink_pkg::SYNC_W; gi++) begin : g_filt
      assign nxt_filt[gi] = (s2_ff[gi] == s3_ff[gi]) ? s3_ff[gi] :
                            filt_ff[gi];
    end
  endgenerate

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s1_ff <= blink_pkg::SYNC_RESET;
      s2_ff <= blink_pkg::SYNC_RESET;
      s3_ff <= blink_pkg::SYNC_RESET;
      filt_ff <= blink_pkg::SYNC_RESET;
    end else begin
      s1_ff <= raw_in;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      filt_ff <= nxt_filt;
    end
  end

  wire scl = filt_ff[0];
  wire sda = filt_ff[1];
  wire [15:0] pin_level = filt_ff[17:2];
  wire [2:0] addr_strap = filt_ff[20:18];

  logic scl_prev_ff;
  logic sda_prev_ff;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      scl_prev_ff <= 1'b1;
      sda_prev_ff <= 1'b1;
    end else begin
      scl_prev_ff <= scl;
      sda_prev_ff <= sda;
    end
  end

  wire scl_rise = scl && !scl_prev_ff;
  wire scl_fall = !scl && scl_prev_ff;
  wire scl_held = scl && scl_prev_ff;
  wire start_seen = scl_held && sda_prev_ff && !sda;
  wire stop_seen = scl_held && !sda_prev_ff && sda;

  // ---------------------------------------------------------------
  // Base step tick, 256 steps per 1/44 s
  // ---------------------------------------------------------------
  logic [blink_pkg::STEP_CNT_W-1:0] step_cnt_ff;
  wire step_tick = (step_cnt_ff == blink_pkg::STEP_LAST);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      step_cnt_ff <= '0;
    end else begin
      step_cnt_ff <= step_tick ? '0 : step_cnt_ff + 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Register file
  // ---------------------------------------------------------------
  logic [7:0] ctrl_ff;
  logic [7:0] nxt_ctrl;
  logic [7:0] period_ff [2];
  logic [7:0] duty_ff [2];
  logic [7:0] route_ff [4];
  logic wr_en;
  logic [7:0] shreg_ff;

  wire [3:0] ptr = ctrl_ff[3:0];
  wire auto_step_flag = ctrl_ff[blink_pkg::CTRL_AUTO_STEP_BIT];
  wire [3:0] ptr_inc = (ptr == blink_pkg::PTR_LAST) ?
                       blink_pkg::PTR_ZERO : ptr + blink_pkg::PTR_ONE;
  wire [7:0] ctrl_stepped = auto_step_flag ? {ctrl_ff[7:4], ptr_inc} :
                            ctrl_ff;

  blink_if wave_bus[2] ();
  wire [1:0] wave;

  generate
    for (gi = 0; gi < 2; gi++) begin : g_gen
      wire [3:0] ptr_period = blink_pkg::PTR_BLINK_A_PERIOD + 4'(2 * gi);
      wire [3:0] ptr_duty = blink_pkg::PTR_BLINK_A_DUTY + 4'(2 * gi);
      wire wr_period = wr_en && (ptr == ptr_period);
      wire wr_duty = wr_en && (ptr == ptr_duty);

      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          period_ff[gi] <= blink_pkg::PERIOD_RESET;
          duty_ff[gi] <= blink_pkg::DUTY_RESET;
        end else begin
          if (wr_period) begin
            period_ff[gi] <= shreg_ff;
          end
          if (wr_duty) begin
            duty_ff[gi] <= shreg_ff;
          end
        end
      end

      assign wave_bus[gi].step_tick = step_tick;
      assign wave_bus[gi].period = period_ff[gi];
      assign wave_bus[gi].duty = duty_ff[gi];
      assign wave[gi] = wave_bus[gi].wave;

      blink_gen u_gen (
        .clk(clk),
        .reset_n(reset_n),
        .bus(wave_bus[gi].gen)
      );
    end

    for (gi = 0; gi < 4; gi++) begin : g_route
      wire [3:0] ptr_route = blink_pkg::PTR_ROUTE_0_3 + 4'(gi);
      wire wr_route = wr_en && (ptr == ptr_route);

      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          route_ff[gi] <= blink_pkg::ROUTE_RESET;
        end else if (wr_route) begin
          route_ff[gi] <= shreg_ff;
        end
      end
    end
  endgenerate

  // Level registers have no storage, so writes to them fall through.
  wire [7:0] rd_data =
    (ptr == blink_pkg::PTR_LEVEL_LOW) ? pin_level[7:0] :
    (ptr == blink_pkg::PTR_LEVEL_HIGH) ? pin_level[15:8] :
    (ptr == blink_pkg::PTR_BLINK_A_PERIOD) ? period_ff[0] :
    (ptr == blink_pkg::PTR_BLINK_A_DUTY) ? duty_ff[0] :
    (ptr == blink_pkg::PTR_BLINK_B_PERIOD) ? period_ff[1] :
    (ptr == blink_pkg::PTR_BLINK_B_DUTY) ? duty_ff[1] :
    (ptr == blink_pkg::PTR_ROUTE_0_3) ? route_ff[0] :
    (ptr == blink_pkg::PTR_ROUTE_4_7) ? route_ff[1] :
    (ptr == blink_pkg::PTR_ROUTE_8_11) ? route_ff[2] :
    (ptr == blink_pkg::PTR_ROUTE_12_15) ? route_ff[3] : 8'h00;

  // ---------------------------------------------------------------
  // Serial bus slave engine
  // ---------------------------------------------------------------
  bus_state_t st_ff;
  bus_state_t nxt_st;
  logic [3:0] bit_cnt_ff;
  logic [3:0] nxt_bit_cnt;
  logic [7:0] nxt_shreg;
  logic ack_ff;
  logic nxt_ack;
  logic sda_oe_ff;
  logic nxt_sda_oe;

  wire addr_hit = (shreg_ff[7:1] == {blink_pkg::DEV_PREFIX, addr_strap});
  wire rw_read = shreg_ff[0];
  wire byte_done = (bit_cnt_ff == blink_pkg::BITS_PER_BYTE);

  always_comb begin
    nxt_st = st_ff;
    nxt_bit_cnt = bit_cnt_ff;
    nxt_shreg = shreg_ff;
    nxt_ack = ack_ff;
    nxt_sda_oe = sda_oe_ff;
    nxt_ctrl = ctrl_ff;
    wr_en = 1'b0;
    if (stop_seen) begin
      nxt_st = ST_IDLE;
      nxt_ack = 1'b0;
      nxt_sda_oe = 1'b0;
    end else if (start_seen) begin
      nxt_st = ST_ADDR;
      nxt_bit_cnt = blink_pkg::BIT_ZERO;
      nxt_ack = 1'b0;
      nxt_sda_oe = 1'b0;
    end else begin
      case (st_ff)
        ST_ADDR, ST_CTRL, ST_WRITE: begin
          if (!ack_ff) begin
            if (scl_rise && !byte_done) begin
              nxt_shreg = {shreg_ff[6:0], sda};
              nxt_bit_cnt = bit_cnt_ff + blink_pkg::BIT_ONE;
            end
            if (scl_fall && byte_done) begin
              nxt_bit_cnt = blink_pkg::BIT_ZERO;
              nxt_ack = 1'b1;
              nxt_sda_oe = 1'b1;
              if (st_ff == ST_ADDR && !addr_hit) begin
                nxt_st = ST_IDLE;
                nxt_ack = 1'b0;
                nxt_sda_oe = 1'b0;
              end else if (st_ff == ST_CTRL) begin
                nxt_ctrl = shreg_ff;
              end else if (st_ff == ST_WRITE) begin
                wr_en = 1'b1;
                nxt_ctrl = ctrl_stepped;
              end
            end
          end else if (scl_fall) begin
            nxt_ack = 1'b0;
            nxt_sda_oe = 1'b0;
            if (st_ff == ST_ADDR && rw_read) begin
              nxt_st = ST_READ;
              nxt_shreg = rd_data;
              nxt_sda_oe = !rd_data[7];
            end else if (st_ff == ST_ADDR) begin
              nxt_st = ST_CTRL;
            end else begin
              nxt_st = ST_WRITE;
            end
          end
        end
        ST_READ: begin
          if (!ack_ff) begin
            if (scl_rise) begin
              nxt_bit_cnt = bit_cnt_ff + blink_pkg::BIT_ONE;
            end
            if (scl_fall && byte_done) begin
              nxt_sda_oe = 1'b0;
              nxt_ack = 1'b1;
              nxt_bit_cnt = blink_pkg::BIT_ZERO;
              nxt_ctrl = ctrl_stepped;
            end else if (scl_fall) begin
              nxt_shreg = {shreg_ff[6:0], 1'b0};
              nxt_sda_oe = !shreg_ff[6];
            end
          end else if (scl_rise && sda) begin
            nxt_st = ST_IDLE;
            nxt_ack = 1'b0;
          end else if (scl_fall) begin
            nxt_ack = 1'b0;
            nxt_shreg = rd_data;
            nxt_sda_oe = !rd_data[7];
          end
        end
        default: begin
          nxt_st = ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_ff <= ST_IDLE;
      bit_cnt_ff <= blink_pkg::BIT_ZERO;
      shreg_ff <= 8'h00;
      ack_ff <= 1'b0;
      sda_oe_ff <= 1'b0;
      ctrl_ff <= blink_pkg::CTRL_RESET;
    end else begin
      st_ff <= nxt_st;
      bit_cnt_ff <= nxt_bit_cnt;
      shreg_ff <= nxt_shreg;
      ack_ff <= nxt_ack;
      sda_oe_ff <= nxt_sda_oe;
      ctrl_ff <= nxt_ctrl;
    end
  end

  // ---------------------------------------------------------------
  // Pin drivers
  // ---------------------------------------------------------------
  logic [15:0] pin_oe_ff;
  logic [15:0] nxt_pin_oe;

  generate
    for (gi = 0; gi < 16; gi++) begin : g_pin
      wire [1:0] sel = route_ff[gi / 4][2 * (gi % 4) +: 2];
      assign nxt_pin_oe[gi] =
        (sel == blink_pkg::SEL_LOW) ? 1'b1 :
        (sel == blink_pkg::SEL_HIZ) ? 1'b0 :
        (sel == blink_pkg::SEL_WAVE_A) ? !wave[0] : !wave[1];
    end
  endgenerate

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_oe_ff <= 16'h0000;
    end else begin
      pin_oe_ff <= nxt_pin_oe;
    end
  end

  assign driver_pin_oe = pin_oe_ff;
  assign driver_pin_out = 16'h0000;
  assign sda_oe = sda_oe_ff;
  assign sda_out = 1'b0;

endmodule

// *** serial_master.sv ***
`timescale 1ns/100ps
module serial_master #(
  parameter int QUARTER_NS = 100
) (
  // Bus lines
  output logic scl,
  output logic sda_pull,
  input wire logic sda
);
  // --------
  // Bus master
  // --------
  // The clock stands high and the data line is released between frames.
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end

  task automatic start();
    #QUARTER_NS sda_pull = 1'b0;
    #QUARTER_NS scl = 1'b1;
    #QUARTER_NS sda_pull = 1'b1;
    #QUARTER_NS scl = 1'b0;
  endtask

  task automatic stop();
    #QUARTER_NS sda_pull = 1'b1;
    #QUARTER_NS scl = 1'b1;
    #QUARTER_NS sda_pull = 1'b0;
    #QUARTER_NS;
  endtask

  // Data moves only while the clock is low.
  task automatic bit_xfer(input logic b, output logic r);
    #QUARTER_NS sda_pull = !b;
    #QUARTER_NS scl = 1'b1;
    #QUARTER_NS r = sda;
    #QUARTER_NS scl = 1'b0;
  endtask

  task automatic put_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_xfer(d[i], r);
    bit_xfer(1'b1, ack);
  endtask

  task automatic get_byte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_xfer(1'b1, d[i]);
    bit_xfer(last, r);
  endtask
endmodule

// *** tb_dual_rate_led_blinker.sv ***
`timescale 1ns/100ps
module tb_dual_rate_led_blinker;
  // --------
  // Signals
  // --------
  logic clk;
  logic reset_n;
  logic [2:0] addr_pin;
  logic [15:0] ext_low;
  logic scl_in;
  logic sda_pull;
  logic sda_out;
  logic sda_oe;
  logic [15:0] driver_pin_out;
  logic [15:0] driver_pin_oe;
  logic ack;
  logic [7:0] pa, da, pb, db;
  int mismatches;
  int checks;
  int cyc;
  int rst_cyc;
  int tw_a;
  int tw_b;
  logic [7:0] regs [10];
  logic [7:0] wq [$];
  // The data line and driver pins have pull-ups; a line is low if any party pulls it.
  wire sda_in = !(sda_pull || sda_oe);
  wire [15:0] driver_pin_in = ~(driver_pin_oe | ext_low);

  dual_rate_led_blinker dual_rate_led_blinker_inst (.clk, .reset_n,
    .scl_in, .sda_in, .sda_out, .sda_oe, .addr_pin, .driver_pin_in,
    .driver_pin_out, .driver_pin_oe);
  serial_master serial_master_inst (.scl(scl_in), .sda_pull,
    .sda(sda_in));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) cyc++;

  // --------
  // Helpers
  // --------
  function automatic logic [15:0] exp_oe();
    logic [15:0] o;
    for (int i = 0; i < 16; i++)
      o[i] = regs[6 + i / 4][2 * (i % 4) +: 2] == blink_pkg::SEL_LOW;
    return o;
  endfunction
  function automatic logic [7:0] exp_reg(input int p);
    logic [15:0] lv;
    lv = ~(exp_oe() | ext_low);
    if (p == 0) return lv[7:0];
    if (p == 1) return lv[15:8];
    return regs[p];
  endfunction
  function automatic logic near(input int t, input int steps);
    int d;
    d = t - steps * int'(blink_pkg::STEP_CYCLES);
    return d >= -16 && d <= 16;
  endfunction
  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic do_reset();
    @(negedge clk);
    reset_n = 1'b0;
    repeat (6) @(negedge clk);
    reset_n = 1'b1;
    rst_cyc = cyc;
    for (int p = 2; p < 10; p++)
      regs[p] = p > 5 ? blink_pkg::ROUTE_RESET : p % 2 ?
        blink_pkg::DUTY_RESET : blink_pkg::PERIOD_RESET;
  endtask
  task automatic wr(input logic [7:0] ctrl);
    serial_master_inst.start();
    serial_master_inst.put_byte({blink_pkg::DEV_PREFIX, addr_pin, 1'b0}, ack);
    check("write ack", ack, 1'b0);
    serial_master_inst.put_byte(ctrl, ack);
    foreach (wq[i])
      serial_master_inst.put_byte(wq[i], ack);
    serial_master_inst.stop();
    wq.delete();
  endtask
  task automatic rd(input logic [7:0] ctrl, input int n);
    logic [7:0] d;
    int p;
    p = ctrl[3:0];
    serial_master_inst.start();
    serial_master_inst.put_byte({blink_pkg::DEV_PREFIX, addr_pin, 1'b0}, ack);
    serial_master_inst.put_byte(ctrl, ack);
    serial_master_inst.start();
    serial_master_inst.put_byte({blink_pkg::DEV_PREFIX, addr_pin, 1'b1}, ack);
    check("read ack", ack, 1'b0);
    for (int i = 0; i < n; i++) begin
      serial_master_inst.get_byte(i == n - 1, d);
      check("read data", d, exp_reg(p));
      if (ctrl[4]) p = p == 9 ? 0 : p + 1;
    end
    serial_master_inst.stop();
  endtask

  // --------
  // Tests
  // --------
  initial begin
    reset_n = 1'b0;
    addr_pin = 3'h0;
    ext_low = 16'h0000;
    void'($urandom(34));
    @(negedge clk);
    addr_pin = 3'($urandom);
    ext_low = 16'($urandom);
    do_reset();
    check("pins after reset", driver_pin_oe, 16'h0000);
    check("open drain", driver_pin_out, 16'h0000);
    check("data drive", sda_out, 1'b0);
    rd(8'h12, 10);
    $display("test defaults done");
    for (int p = 2; p < 12; p++) begin
      if (p < 10) regs[p] = 8'($urandom) & (p > 5 ? 8'h55 : 8'hFF);
      wq.push_back(p < 10 ? regs[p] : 8'($urandom));
    end
    wr(8'h12);
    @(negedge clk);
    ext_low = 16'($urandom);
    rd(8'h12, 10);
    check("route pins", driver_pin_oe, exp_oe());
    $display("test random registers done");
    wq = '{8'h55, 8'h14};
    regs[8] = 8'h14;
    wr(8'h08);
    rd(8'h08, 3);
    $display("test fixed pointer done");
    serial_master_inst.start();
    serial_master_inst.put_byte({blink_pkg::DEV_PREFIX, ~addr_pin, 1'b0}, ack);
    check("foreign ack", ack, 1'b1);
    serial_master_inst.stop();
    $display("test foreign address done");
    do_reset();
    rd(8'h12, 8);
    pa = 8'($urandom % 3);
    da = 8'(1 + $urandom % 2);
    pb = 8'($urandom % 3);
    db = 8'(1 + $urandom % 2);
    wq = '{pa, da, pb, db, 8'hE4};
    wr(8'h12);
    check("selector codes", driver_pin_oe[3:0], 4'hD);
    tw_a = 0;
    tw_b = 0;
    for (int i = 0; i < 30000 && (tw_a == 0 || tw_b == 0); i++) begin
      @(negedge clk);
      if (tw_a == 0 && !driver_pin_oe[2]) tw_a = cyc - rst_cyc;
      if (tw_b == 0 && !driver_pin_oe[3]) tw_b = cyc - rst_cyc;
    end
    if (tw_a == 0 || tw_b == 0) begin
      mismatches++;
      $display("[ERR] wave rise expected edge seen none");
      results();
    end
    check("wave a rise", near(tw_a, da * (pa + 1)), 1'b1);
    check("wave b rise", near(tw_b, db * (pb + 1)), 1'b1);
    wq = '{8'h00};
    wr(8'h03);
    repeat (8) @(negedge clk);
    check("duty zero", driver_pin_oe[3:2], 2'h1);
    repeat (8000) @(negedge clk);
    check("duty zero held", driver_pin_oe[3:2], 2'h1);
    $display("test blink timing done");
    results();
  end
endmodule
